// ===== shared/clock_generation_unit_pkg.sv
// package: constants and carrier types for the clock generation unit
package clock_generation_unit_pkg;
    localparam int unsigned MULT_W        = 6;
    localparam int unsigned DIV_W         = 4;
    localparam int unsigned KEY_W         = 5;
    localparam logic [5:0]  MULT_RESET    = 6'h14;
    localparam logic [3:0]  DIV_RESET     = 4'h2;
    localparam logic [3:0]  PDIV_FIXED    = 4'h1;
    localparam logic [4:0]  KEY_OPEN      = 5'h13;
    localparam logic [4:0]  KEY_CLOSE     = 5'h15;
    localparam logic [4:0]  KEY_DISABLE   = 5'h18;
    localparam logic [1:0]  MODE_ENABLED  = 2'h3;
    localparam logic [1:0]  MODE_DISABLED = 2'h0;
    localparam int unsigned OPEN_CYCLES   = 32;
    localparam int unsigned OPEN_CNT_W    = 6;

    typedef enum logic [1:0] {
        MODE_BASE,
        MODE_PRESCALER,
        MODE_LOOP
    } clock_mode_e;

    typedef struct packed {
        logic [5:0] multiplier;
        logic [3:0] divider;
    } divider_cfg_s;

    typedef struct packed {
        logic       write;
        logic [1:0] mode;
        logic [4:0] key;
    } key_write_s;
endpackage : clock_generation_unit_pkg

// ===== rtl/system_clock_generation.sv
// system clock generation: protected divider settings and mode-steered clock division
// Operation
// - base mode: system clock is free-running vco base divided by K
// - prescaler mode: system clock is oscillator divided by P times K
// - loop mode: oscillator times N over P times K, at most one tick per oscillator edge; both bypasses inactive
// - loop mode is the clocking mode for normal operation
// - P is fixed at one and not programmable
// - N and K come from software-writable multiplier and divider fields
// - N and K writes take effect only while protection is unlocked
`timescale 1ns/10ps
`default_nettype none
module system_clock_generation #(
    parameter int unsigned ACC_W = 16
) (
    input  wire logic                                     clk,
    input  wire logic                                     rst_b,
    input  wire clock_generation_unit_pkg::key_write_s    keyWrite,
    input  wire logic                                     cfgWrite,
    input  wire clock_generation_unit_pkg::divider_cfg_s  cfgData,
    input  wire logic                                     oscDetached,
    input  wire logic                                     vcoBypass,
    input  wire logic                                     loopBypass,
    input  wire logic                                     oscTick,
    input  wire logic                                     vcoBaseTick,
    output logic                                          sysTick,
    output var clock_generation_unit_pkg::divider_cfg_s   activeCfg,
    output var clock_generation_unit_pkg::clock_mode_e    clockMode,
    output logic                                          writeOpen,
    output logic [1:0]                                    protectMode
);
    // oscTick / vcoBaseTick are one-cycle pulses marking source clock edges;
    // sysTick pulses once per derived system clock period
    // six count bits cover the 32-cycle window; a window longer than 63 cycles needs a wider counter
    localparam logic [5:0] OPEN_LOAD = 6'(clock_generation_unit_pkg::OPEN_CYCLES);

    clock_generation_unit_pkg::divider_cfg_s cfg;
    clock_generation_unit_pkg::divider_cfg_s next_cfg;
    logic [1:0]       next_protectMode;
    logic [5:0]       openCnt;
    logic [5:0]       next_openCnt;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] next_acc;
    logic             next_sysTick;
    clock_generation_unit_pkg::clock_mode_e next_clockMode;

    // protection: open lasts 32 cycles, reopen restarts count, close ends it
    always_comb begin
        next_protectMode = protectMode;
        next_openCnt     = (openCnt != 6'h00) ? openCnt - 6'h01 : 6'h00;
        if (keyWrite.write) begin
            // disable key is honoured in every mode, so it can also re-enable protection
            if (keyWrite.key == clock_generation_unit_pkg::KEY_DISABLE) begin
                next_protectMode = keyWrite.mode;
            end else if (protectMode == clock_generation_unit_pkg::MODE_ENABLED) begin
                if (keyWrite.key == clock_generation_unit_pkg::KEY_OPEN) begin
                    next_openCnt = OPEN_LOAD;
                end else if (keyWrite.key == clock_generation_unit_pkg::KEY_CLOSE) begin
                    next_openCnt = 6'h00;
                end
            end
        end
    end

    // any mode other than enabled leaves the settings writable with no key at all
    assign writeOpen = (protectMode != clock_generation_unit_pkg::MODE_ENABLED) ||
                       (openCnt != 6'h00);

    always_comb begin
        next_cfg = cfg;
        // a refused write is dropped silently; software sees it only by reading back
        if (cfgWrite && writeOpen) begin
            next_cfg = cfgData;
        end
    end

    // mode select: loop only when neither bypass is active
    always_comb begin
        if (oscDetached) begin
            next_clockMode = clock_generation_unit_pkg::MODE_BASE;
        end else if (vcoBypass) begin
            next_clockMode = clock_generation_unit_pkg::MODE_PRESCALER;
        end else if (!loopBypass) begin
            next_clockMode = clock_generation_unit_pkg::MODE_LOOP;
        end else begin
            // loop bypass alone leaves no loop output, so fall back to the prescaler path
            next_clockMode = clock_generation_unit_pkg::MODE_PRESCALER;
        end
    end

    // fractional accumulator: adds N per oscillator edge in loop mode, 1 otherwise,
    // and emits a tick each time P*K is reached; P is a fixed constant
    // the remainder survives a mode change, so the first tick after a switch may come early
    function automatic logic [ACC_W-1:0] periodOf(input logic [3:0] k);
        return ACC_W'(clock_generation_unit_pkg::PDIV_FIXED) * ACC_W'(k);
    endfunction

    always_comb begin
        logic             step;
        logic [ACC_W-1:0] inc;
        logic [ACC_W-1:0] sum;
        step         = 1'b0;
        inc          = '0;
        sum          = '0;
        next_sysTick = 1'b0;
        next_acc     = acc;
        unique case (clockMode)
            clock_generation_unit_pkg::MODE_BASE: begin
                step = vcoBaseTick;
                inc  = ACC_W'(1);
            end
            clock_generation_unit_pkg::MODE_PRESCALER: begin
                step = oscTick;
                inc  = ACC_W'(1);
            end
            clock_generation_unit_pkg::MODE_LOOP: begin
                step = oscTick;
                inc  = ACC_W'(cfg.multiplier);
            end
            default: begin
                step = 1'b0;
            end
        endcase
        if (step && cfg.divider != 4'h0) begin
            sum = acc + inc;
            // one tick per step at most: loop output above the step rate saturates
            if (sum >= periodOf(cfg.divider)) begin
                next_sysTick = 1'b1;
                next_acc     = sum - periodOf(cfg.divider);
                if (next_acc >= periodOf(cfg.divider)) begin
                    next_acc = '0;
                end
            end else begin
                next_acc = sum;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            protectMode <= clock_generation_unit_pkg::MODE_ENABLED;
            openCnt     <= 6'h00;
            cfg         <= '{multiplier: clock_generation_unit_pkg::MULT_RESET,
                             divider:    clock_generation_unit_pkg::DIV_RESET};
            clockMode   <= clock_generation_unit_pkg::MODE_LOOP;
            acc         <= '0;
            sysTick     <= 1'b0;
        end else begin
            protectMode <= next_protectMode;
            openCnt     <= next_openCnt;
            cfg         <= next_cfg;
            clockMode   <= next_clockMode;
            acc         <= next_acc;
            sysTick     <= next_sysTick;
        end
    end

    assign activeCfg = cfg;

    // every check below looks one cycle past its cause, since all outputs are registered or, like writeOpen, decoded from registers

    locked_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        (cfgWrite && !writeOpen) |=> $stable(activeCfg))
        else $error("divider settings changed while locked");

    open_write_a: assert property (@(posedge clk) disable iff (!rst_b)
        (cfgWrite && writeOpen) |=> (activeCfg == $past(cfgData)))
        else $error("unlocked write not taken");

    // the window is checked as a reload plus a countdown, so a close key inside it stays legal
    open_window_a: assert property (@(posedge clk) disable iff (!rst_b)
        (keyWrite.write && keyWrite.key == clock_generation_unit_pkg::KEY_OPEN &&
         protectMode == clock_generation_unit_pkg::MODE_ENABLED) |=>
        ((openCnt == OPEN_LOAD) && writeOpen))
        else $error("open window not reloaded");

    open_count_a: assert property (@(posedge clk) disable iff (!rst_b)
        (openCnt != 6'h00 && !keyWrite.write) |=> (openCnt == $past(openCnt) - 6'h01))
        else $error("open window not counting down");

    close_key_a: assert property (@(posedge clk) disable iff (!rst_b)
        (keyWrite.write && keyWrite.key == clock_generation_unit_pkg::KEY_CLOSE &&
         protectMode == clock_generation_unit_pkg::MODE_ENABLED) |=> !writeOpen)
        else $error("close key left settings writable");

    disable_key_a: assert property (@(posedge clk) disable iff (!rst_b)
        (keyWrite.write && keyWrite.key == clock_generation_unit_pkg::KEY_DISABLE) |=>
        (protectMode == $past(keyWrite.mode)))
        else $error("protection mode not taken from disable key");

    base_mode_a: assert property (@(posedge clk) disable iff (!rst_b)
        oscDetached |=> (clockMode == clock_generation_unit_pkg::MODE_BASE))
        else $error("base mode not chosen");

    prescale_mode_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!oscDetached && vcoBypass) |=>
        (clockMode == clock_generation_unit_pkg::MODE_PRESCALER))
        else $error("prescaler mode not chosen");

    loop_mode_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!oscDetached && !vcoBypass && !loopBypass) |=>
        (clockMode == clock_generation_unit_pkg::MODE_LOOP))
        else $error("loop mode not chosen");

    tick_cause_a: assert property (@(posedge clk) disable iff (!rst_b)
        sysTick |-> ($past(oscTick) || $past(vcoBaseTick)))
        else $error("system tick without source edge");

    prescale_div_a: assert property (@(posedge clk) disable iff (!rst_b)
        (clockMode == clock_generation_unit_pkg::MODE_PRESCALER && oscTick &&
         activeCfg.divider == 4'h1) |=> sysTick)
        else $error("divide by P*K of one missed a tick");

    div_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
        (activeCfg.divider == 4'h0) |=> !sysTick)
        else $error("system tick with a zero divider");

    loop_sat_a: assert property (@(posedge clk) disable iff (!rst_b)
        (clockMode == clock_generation_unit_pkg::MODE_LOOP && oscTick &&
         activeCfg.divider != 4'h0 && {2'b00, activeCfg.divider} <= activeCfg.multiplier) |=>
        sysTick)
        else $error("loop step with N at least K gave no tick");
endmodule : system_clock_generation
`default_nettype wire

// ===== verif/test_system_clock_generation.sv
// self-checking testbench for the system clock generation block
`timescale 1ns/10ps
`default_nettype none
module test_system_clock_generation;
    logic                                    clk = 1'b0;
    logic                                    rst_b = 1'b0;
    clock_generation_unit_pkg::key_write_s   keyWrite = '0;
    logic                                    cfgWrite = 1'b0;
    clock_generation_unit_pkg::divider_cfg_s cfgData = '0;
    logic                                    oscDetached = 1'b0;
    logic                                    vcoBypass = 1'b0;
    logic                                    loopBypass = 1'b0;
    logic                                    oscTick = 1'b0;
    logic                                    vcoBaseTick = 1'b0;
    logic                                    sysTick;
    logic                                    writeOpen;
    logic [1:0]                              protectMode;
    clock_generation_unit_pkg::divider_cfg_s activeCfg;
    clock_generation_unit_pkg::clock_mode_e  clockMode;
    int                                      nMismatch = 0;
    int                                      numChecks = 0;
    int                                      nTick = 0;

    system_clock_generation i_system_clock_generation (
        .clk(clk), .rst_b(rst_b), .keyWrite(keyWrite), .cfgWrite(cfgWrite),
        .cfgData(cfgData), .oscDetached(oscDetached), .vcoBypass(vcoBypass),
        .loopBypass(loopBypass), .oscTick(oscTick), .vcoBaseTick(vcoBaseTick),
        .sysTick(sysTick), .activeCfg(activeCfg), .clockMode(clockMode),
        .writeOpen(writeOpen), .protectMode(protectMode));

    always #2 clk = ~clk;
    always @(posedge clk) if (sysTick === 1'b1) nTick <= nTick + 1;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic keyPut(input logic [1:0] mode, input logic [4:0] key);
        @(posedge clk);
        #1 keyWrite = '{write: 1'b1, mode: mode, key: key};
        @(posedge clk);
        #1 keyWrite.write = 1'b0;
    endtask : keyPut

    task automatic cfgPut(input logic [5:0] n, input logic [3:0] k);
        @(posedge clk);
        #1 cfgData = '{multiplier: n, divider: k};
        cfgWrite = 1'b1;
        @(posedge clk);
        #1 cfgWrite = 1'b0;
    endtask : cfgPut

    task automatic modeSet(input logic d, input logic v, input logic l, input logic [1:0] exp);
        oscDetached = d;
        vcoBypass = v;
        loopBypass = l;
        repeat (2) @(posedge clk);
        #1 check("clockMode", 16'(clockMode), 16'(exp));
    endtask : modeSet

    // one step every other cycle, then room for the registered tick to land
    task automatic steps(input logic base, input int n, input int exp, input string what);
        int t0;
        t0 = nTick;
        repeat (n) begin
            @(posedge clk);
            #1 if (base) vcoBaseTick = 1'b1; else oscTick = 1'b1;
            @(posedge clk);
            #1 vcoBaseTick = 1'b0;
            oscTick = 1'b0;
        end
        repeat (4) @(posedge clk);
        #1 check(what, 16'(nTick - t0), 16'(exp));
    endtask : steps

    task automatic endOfTest;
        $display("checks %0d, mismatches %0d", numChecks, nMismatch);
        if (nMismatch == 0 && numChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : endOfTest

    initial begin
        #20000;
        nMismatch++;
        $display("watchdog expired");
        endOfTest();
    end

    initial begin
        repeat (3) @(posedge clk);
        #1 rst_b = 1'b1;
        check("protectMode", 16'(protectMode), 16'h3);
        check("writeOpen", 16'(writeOpen), 16'h0);
        check("activeCfg", 16'(activeCfg), 16'h142);
        check("clockMode", 16'(clockMode), 16'(clock_generation_unit_pkg::MODE_LOOP));
        $display("test done: reset");
        cfgPut(6'h01, 4'h4);
        check("activeCfg", 16'(activeCfg), 16'h142);
        keyPut(clock_generation_unit_pkg::MODE_ENABLED, clock_generation_unit_pkg::KEY_OPEN);
        check("writeOpen", 16'(writeOpen), 16'h1);
        repeat (31) @(posedge clk);
        #1 check("writeOpen", 16'(writeOpen), 16'h1);
        @(posedge clk);
        #1 check("writeOpen", 16'(writeOpen), 16'h0);
        keyPut(clock_generation_unit_pkg::MODE_ENABLED, clock_generation_unit_pkg::KEY_OPEN);
        keyPut(clock_generation_unit_pkg::MODE_ENABLED, 5'h00);
        check("writeOpen", 16'(writeOpen), 16'h1);
        keyPut(clock_generation_unit_pkg::MODE_ENABLED, clock_generation_unit_pkg::KEY_CLOSE);
        check("writeOpen", 16'(writeOpen), 16'h0);
        $display("test done: protection");
        modeSet(1'b1, 1'b0, 1'b0, clock_generation_unit_pkg::MODE_BASE);
        steps(1'b1, 8, 4, "base ticks");
        modeSet(1'b0, 1'b1, 1'b0, clock_generation_unit_pkg::MODE_PRESCALER);
        steps(1'b0, 8, 4, "prescaler ticks");
        modeSet(1'b0, 1'b0, 1'b1, clock_generation_unit_pkg::MODE_PRESCALER);
        modeSet(1'b0, 1'b0, 1'b0, clock_generation_unit_pkg::MODE_LOOP);
        $display("test done: modes");
        keyPut(clock_generation_unit_pkg::MODE_ENABLED, clock_generation_unit_pkg::KEY_OPEN);
        cfgPut(6'h01, 4'h4);
        check("activeCfg", 16'(activeCfg), 16'h014);
        steps(1'b0, 8, 2, "loop ticks");
        keyPut(clock_generation_unit_pkg::MODE_DISABLED, clock_generation_unit_pkg::KEY_DISABLE);
        check("protectMode", 16'(protectMode), 16'h0);
        cfgPut(6'h18, 4'h2);
        check("activeCfg", 16'(activeCfg), 16'h182);
        steps(1'b0, 8, 8, "saturated ticks");
        $display("test done: loop");
        cfgPut(6'h18, 4'h0);
        check("activeCfg", 16'(activeCfg), 16'h180);
        steps(1'b0, 4, 0, "stopped ticks");
        cfgPut(6'h18, 4'h1);
        modeSet(1'b0, 1'b1, 1'b0, clock_generation_unit_pkg::MODE_PRESCALER);
        steps(1'b0, 4, 4, "unit prescaler ticks");
        $display("test done: divider ends");
        endOfTest();
    end
endmodule : test_system_clock_generation
`default_nettype wire
